// *** verilog/epid_defines.svh ***
// Summary of operation
// - Control bit 5 picks polarity: clear falling/low, set rising/high.
// - Control bit 0 picks edge only, or edge plus matching level.
// - Control bit 4 enables the pin; clear means no requests from it.
// - Enabled pin gets a pull-up for falling, pull-down for rising polarity.
// - Bit 3 is a read-only flag showing a detected request event.
// - Writing 1 to bit 2 clears the flag; 0 does nothing; reads 0.
// - In level mode an acknowledge cannot clear while pin stays asserted.
// - Bit 1 gates the request output; set means request follows the flag.
// - Bits 7 and 6 of the control register always read 0.
// - Edge is deasserted-to-asserted; level mode keeps flag set while asserted.
`ifndef EPID_DEFINES_SVH
`define EPID_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define EPID_OFS_CTRL        12'h000
`define EPID_OFS_INT_STATUS  12'h004
`define EPID_OFS_INT_MASK    12'h008
`define EPID_OFS_PIN_STATE   12'h00c

// ==========================================================
// Control and status fields
`define EPID_BIT_MODE        0
`define EPID_BIT_IE          1
`define EPID_BIT_ACK         2
`define EPID_BIT_FLAG        3
`define EPID_BIT_PE          4
`define EPID_BIT_EDG         5

// ==========================================================
// Interrupt status fields
`define EPID_INT_EVENT       0
`define EPID_INT_ACK_REFUSED 1
`define EPID_INT_WIDTH       2

// ==========================================================
// Pin state fields
`define EPID_PIN_LEVEL       0
`define EPID_PIN_ASSERTED    1
`define EPID_PIN_PULL_UP     2
`define EPID_PIN_PULL_DOWN   3

// ==========================================================
// Reset values
`define EPID_RST_CTRL        6'h00
`define EPID_RST_INT_MASK    2'h0
`define EPID_RST_PIN_LEVEL   1'b0

`endif

// *** verilog/epid_pkg.sv ***
`default_nettype none
package epid_pkg;

    // ======================================================
    // Types
    typedef logic [7:0]  epid_byte_t;
    typedef logic [31:0] epid_word_t;

    typedef enum logic {
        EPID_EDGE_ONLY  = 1'b0,
        EPID_EDGE_LEVEL = 1'b1
    } epid_mode_e;

    typedef enum logic {
        EPID_FALLING = 1'b0,
        EPID_RISING  = 1'b1
    } epid_pol_e;

endpackage : epid_pkg
`default_nettype wire

// *** verilog/epid_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module epid_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Asynchronous level in, settled level out
    input  wire logic async_in,
    output var  logic sync_out
);

    logic stage1;
    logic stage2;
    logic stage3;

    // ======================================================
    // Three-flop chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // ======================================================
    // Accept a change once the last two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= RESET_LEVEL;
        end else if (stage2 == stage3) begin
            sync_out <= stage3;
        end
    end

endmodule : epid_sync
`default_nettype wire

// *** verilog/epid_top.sv ***
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "epid_defines.svh"
module epid_top #(
    parameter int ADDR_W = 12
) (
    // APB clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // External request pin
    input  wire logic              request_pin,
    output var  logic              pull_up_en,
    output var  logic              pull_down_en,
    // Requests toward the core
    output var  logic              request_irq,
    output var  logic              irq
);

    // ======================================================
    // Declarations
    logic                      request_detect_mode;
    logic                      request_interrupt_enable;
    logic                      request_pin_enable;
    logic                      request_edge_polarity;
    logic                      request_event_flag;
    logic                      pin_level;
    logic                      pin_asserted;
    logic                      prev_asserted;
    logic                      edge_event;
    logic                      level_event;
    logic                      set_event;
    logic                      ack_write;
    logic                      ack_refused;
    logic [`EPID_INT_WIDTH-1:0] int_status;
    logic [`EPID_INT_WIDTH-1:0] int_mask;
    logic [`EPID_INT_WIDTH-1:0] int_set;
    logic                      setup_phase;
    logic                      access_phase;
    logic                      wr_take;
    logic                      lane0_wr;
    logic                      addr_ok;
    logic                      sel_ctrl;
    logic                      sel_status;
    logic                      sel_mask;
    logic                      sel_pin;
    epid_pkg::epid_byte_t      ctrl_view;
    epid_pkg::epid_byte_t      pin_view;
    epid_pkg::epid_word_t      next_rdata;
    epid_pkg::epid_mode_e      mode_sel;
    epid_pkg::epid_pol_e       pol_sel;

    // Control reset word, so single fields can be picked from it
    localparam logic [5:0] RST_CTRL = `EPID_RST_CTRL;

    // ======================================================
    // Pin synchroniser
    epid_sync #(
        .RESET_LEVEL (`EPID_RST_PIN_LEVEL)
    ) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (request_pin),
        .sync_out (pin_level)
    );

    // ======================================================
    // APB phase decode
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign pready       = 1'b1;
    assign wr_take      = access_phase & pready & pwrite;
    assign lane0_wr     = wr_take & pstrb[0];

    always_comb begin
        sel_ctrl   = (paddr == `EPID_OFS_CTRL);
        sel_status = (paddr == `EPID_OFS_INT_STATUS);
        sel_mask   = (paddr == `EPID_OFS_INT_MASK);
        sel_pin    = (paddr == `EPID_OFS_PIN_STATE);
        addr_ok    = sel_ctrl | sel_status | sel_mask | sel_pin;
    end

    // ======================================================
    // Control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_detect_mode      <= RST_CTRL[`EPID_BIT_MODE];
            request_interrupt_enable <= RST_CTRL[`EPID_BIT_IE];
            request_pin_enable       <= RST_CTRL[`EPID_BIT_PE];
            request_edge_polarity    <= RST_CTRL[`EPID_BIT_EDG];
        end else if (lane0_wr && sel_ctrl) begin
            request_detect_mode      <= pwdata[`EPID_BIT_MODE];
            request_interrupt_enable <= pwdata[`EPID_BIT_IE];
            request_pin_enable       <= pwdata[`EPID_BIT_PE];
            request_edge_polarity    <= pwdata[`EPID_BIT_EDG];
        end
    end

    assign mode_sel = epid_pkg::epid_mode_e'(request_detect_mode);
    assign pol_sel  = epid_pkg::epid_pol_e'(request_edge_polarity);

    // ======================================================
    // Pull resistor selection
    always_comb begin
        pull_up_en   = 1'b0;
        pull_down_en = 1'b0;
        if (request_pin_enable) begin
            if (pol_sel == epid_pkg::EPID_RISING) begin
                pull_down_en = 1'b1;
            end else begin
                pull_up_en   = 1'b1;
            end
        end
    end

    // ======================================================
    // Edge and level detection
    // Asserted level follows the polarity choice
    assign pin_asserted = (pol_sel == epid_pkg::EPID_RISING) ? pin_level
                                                             : ~pin_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Matches the asserted view of the reset pin level: no false edge
            prev_asserted <= 1'b1;
        end else begin
            prev_asserted <= pin_asserted;
        end
    end

    // Disabled pin raises nothing
    assign edge_event  = request_pin_enable & pin_asserted & ~prev_asserted;
    assign level_event = request_pin_enable & pin_asserted
                       & (mode_sel == epid_pkg::EPID_EDGE_LEVEL);
    assign set_event   = edge_event | level_event;

    // ======================================================
    // Event flag and acknowledge
    assign ack_write = lane0_wr & sel_ctrl & pwdata[`EPID_BIT_ACK];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_event_flag <= 1'b0;
        end else if (set_event) begin
            // Set wins over a same-cycle acknowledge
            request_event_flag <= 1'b1;
        end else if (ack_write) begin
            request_event_flag <= 1'b0;
        end
    end

    // Acknowledge blocked by a held level
    assign ack_refused = ack_write & level_event;

    // ======================================================
    // Request toward the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_irq <= 1'b0;
        end else begin
            request_irq <= request_interrupt_enable
                         & (request_event_flag | set_event);
        end
    end

    // ======================================================
    // Sticky interrupt status and mask
    always_comb begin
        int_set                        = '0;
        int_set[`EPID_INT_EVENT]       = set_event & ~request_event_flag;
        int_set[`EPID_INT_ACK_REFUSED] = ack_refused;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
        end else if (lane0_wr && sel_status) begin
            // Write one to clear, new events kept
            int_status <= (int_status & ~pwdata[`EPID_INT_WIDTH-1:0]) | int_set;
        end else begin
            int_status <= int_status | int_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= `EPID_RST_INT_MASK;
        end else if (lane0_wr && sel_mask) begin
            int_mask <= pwdata[`EPID_INT_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end

    // ======================================================
    // Read views
    always_comb begin
        ctrl_view                    = '0;
        ctrl_view[`EPID_BIT_MODE]    = request_detect_mode;
        ctrl_view[`EPID_BIT_IE]      = request_interrupt_enable;
        ctrl_view[`EPID_BIT_ACK]     = 1'b0;
        ctrl_view[`EPID_BIT_FLAG]    = request_event_flag;
        ctrl_view[`EPID_BIT_PE]      = request_pin_enable;
        ctrl_view[`EPID_BIT_EDG]     = request_edge_polarity;
    end

    always_comb begin
        pin_view                       = '0;
        pin_view[`EPID_PIN_LEVEL]      = pin_level;
        pin_view[`EPID_PIN_ASSERTED]   = pin_asserted;
        pin_view[`EPID_PIN_PULL_UP]    = pull_up_en;
        pin_view[`EPID_PIN_PULL_DOWN]  = pull_down_en;
    end

    always_comb begin
        next_rdata = '0;
        if (sel_ctrl) begin
            next_rdata[7:0] = ctrl_view;
        end else if (sel_status) begin
            next_rdata[`EPID_INT_WIDTH-1:0] = int_status;
        end else if (sel_mask) begin
            next_rdata[`EPID_INT_WIDTH-1:0] = int_mask;
        end else if (sel_pin) begin
            next_rdata[7:0] = pin_view;
        end
    end

    // ======================================================
    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_phase) begin
            prdata <= pwrite ? '0 : next_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= ~addr_ok;
        end
    end

endmodule : epid_top
`default_nettype wire

// *** tb/epid_checker_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module epid_checker #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Pin and requests
    input wire logic              request_pin,
    input wire logic              pull_up_en,
    input wire logic              pull_down_en,
    input wire logic              request_irq,
    input wire logic              irq
);
    // ==========================================================
    // Control shadow
    logic pe_q, edg_q, ie_q, mode_q;
    logic wr_ctl, acc, unmapped;
    assign acc = psel && penable;
    assign wr_ctl = acc && pready && pwrite && pstrb[0] && paddr == '0;
    assign unmapped = (paddr >> 4) != '0 || paddr[1:0] != 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pe_q, edg_q, ie_q, mode_q} <= 4'h0;
        end else if (wr_ctl) begin
            {pe_q, edg_q, ie_q, mode_q} <= {pwdata[4], pwdata[5], pwdata[1], pwdata[0]};
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_held; (pe_q && ie_q && mode_q && request_pin == edg_q) [*8]; endsequence
    property p_held; s_held |-> request_irq; endproperty
    property p_pu; pull_up_en == (pe_q && !edg_q); endproperty
    property p_pd; pull_down_en == (pe_q && edg_q); endproperty
    property p_gate; request_irq |-> $past(ie_q); endproperty
    property p_pin; $rose(request_irq) && $past(ie_q, 2) |-> pe_q || $past(pe_q); endproperty
    property p_rd0; acc && !pwrite && paddr == '0 |-> prdata[31:6] == 26'h0 && !prdata[2];
    endproperty
    property p_rdy; acc |-> pready; endproperty
    property p_bad; acc && unmapped |-> pslverr && prdata == 32'h0; endproperty
    a_held: assert property (p_held) else $error("flag dropped while level held");
    a_pu: assert property (p_pu) else $error("pull-up wrong");
    a_pd: assert property (p_pd) else $error("pull-down wrong");
    a_gate: assert property (p_gate) else $error("request while disabled");
    a_pin: assert property (p_pin) else $error("event with pin off");
    a_rd0: assert property (p_rd0) else $error("fixed-zero bits set");
    a_rdy: assert property (p_rdy) else $error("no ready");
    a_bad: assert property (p_bad) else $error("unmapped access");
endmodule : epid_checker
bind epid_top epid_checker #(.ADDR_W(ADDR_W)) epid_checker_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .request_pin(request_pin), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .request_irq(request_irq), .irq(irq));
`default_nettype wire

// *** tb/epid_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module epid_pin_model (
    // Clock
    input wire logic pclk,
    // Board driver and pulls
    input wire logic drive_en,
    input wire logic drive_val,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    // Pin
    output var logic pin
);
    logic last;
    always_ff @(posedge pclk) begin
        last <= (pin === 1'b1);
    end
    // Floating pin with no pull toggles every cycle
    always_comb begin
        pin = drive_en ? drive_val : pull_up_en ? 1'b1 : pull_down_en ? 1'b0 : ~last;
    end
endmodule : epid_pin_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin;
    logic pull_up_en, pull_down_en, request_irq, irq, drv_en, drv_val;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    int miscompares = 0;
    int compares = 0;
    epid_top epid_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .request_pin(pin), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .request_irq(request_irq), .irq(irq));
    epid_pin_model epid_pin_model_i (.pclk(pclk), .drive_en(drv_en), .drive_val(drv_val),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .pin(pin));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic complete_run();
        $display("miscompares=%0d compares=%0d", miscompares, compares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: word %h, expected %h", $time, g, e);
        end
    endtask : chk_word
    // Lets registered outputs settle before looking
    task automatic settle();
        repeat (2) @(negedge pclk);
    endtask : settle
    task automatic chk_bit(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: bit %b, expected %b", $time, g, e);
        end
    endtask : chk_bit
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk_word(r, x);
        chk_word({31'h0, e}, {31'h0, a > 12'h00c});
    endtask : rd
    task automatic pin_set(input logic en, input logic v);
        @(posedge pclk);
        drv_en <= en;
        drv_val <= v;
        repeat (8) @(posedge pclk);
    endtask : pin_set
    task automatic s_reset();
        rd(12'h000, 32'h0);
        rd(12'h008, 32'h0);
        rd(12'h010, 32'h0);
        settle();
        chk_bit(pull_up_en, 1'b0);
    endtask : s_reset
    task automatic s_pulls();
        wr(12'h000, 32'h10);
        settle();
        chk_bit(pull_up_en, 1'b1);
        wr(12'h000, 32'h30);
        settle();
        chk_bit(pull_down_en, 1'b1);
        wr(12'h000, 32'h00);
        settle();
        chk_bit(pull_down_en, 1'b0);
    endtask : s_pulls
    task automatic s_edge();
        wr(12'h000, 32'h16);
        pin_set(1'b0, 1'b0);
        wr(12'h000, 32'h16);
        rd(12'h000, 32'h12);
        pin_set(1'b1, 1'b0);
        rd(12'h000, 32'h1a);
        settle();
        chk_bit(request_irq, 1'b1);
        wr(12'h000, 32'h10);
        rd(12'h000, 32'h18);
        settle();
        chk_bit(request_irq, 1'b0);
        wr(12'h000, 32'h16);
        rd(12'h000, 32'h12);
        pin_set(1'b0, 1'b0);
        rd(12'h000, 32'h12);
    endtask : s_edge
    task automatic s_level();
        wr(12'h000, 32'h13);
        pin_set(1'b1, 1'b0);
        wr(12'h000, 32'h17);
        rd(12'h000, 32'h1b);
        rd(12'h004, 32'h3);
        rd(12'h00c, 32'h6);
        pin_set(1'b0, 1'b0);
        wr(12'h000, 32'h17);
        rd(12'h000, 32'h13);
    endtask : s_level
    task automatic s_rising();
        wr(12'h000, 32'h32);
        pin_set(1'b0, 1'b0);
        wr(12'h000, 32'h36);
        rd(12'h000, 32'h32);
        pin_set(1'b1, 1'b1);
        rd(12'h000, 32'h3a);
        wr(12'h000, 32'h36);
        wr(12'h000, 32'h02);
        pin_set(1'b1, 1'b0);
        pin_set(1'b1, 1'b1);
        rd(12'h000, 32'h02);
    endtask : s_rising
    task automatic s_irq();
        wr(12'h004, 32'h3);
        rd(12'h004, 32'h0);
        wr(12'h008, 32'h1);
        wr(12'h000, 32'h10);
        pin_set(1'b1, 1'b0);
        settle();
        chk_bit(irq, 1'b1);
        wr(12'h008, 32'h0);
        settle();
        chk_bit(irq, 1'b0);
        wr(12'h008, 32'h1);
        settle();
        chk_bit(irq, 1'b1);
        wr(12'h004, 32'h1);
        settle();
        chk_bit(irq, 1'b0);
    endtask : s_irq
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, drv_en, drv_val} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_pulls();
        s_edge();
        s_level();
        s_rising();
        s_irq();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
